// ### shared/icdt_cfg.svh
// Register map, field positions and reset values of the capture block
`ifndef ICDT_CFG_SVH
`define ICDT_CFG_SVH
`define ICDT_UNITS      5
`define ICDT_UNIT_LSB   4
`define ICDT_UNIT_MSB   6
`define ICDT_REG_LSB    2
`define ICDT_REG_MSB    3
`define ICDT_OFF_CON1   2'h0
`define ICDT_OFF_CON2   2'h1
`define ICDT_OFF_BUF    2'h2
`define ICDT_TSEL_MSB   12
`define ICDT_TSEL_LSB   10
`define ICDT_ICI_MSB    6
`define ICDT_ICI_LSB    5
`define ICDT_OV_BIT     4
`define ICDT_BNE_BIT    3
`define ICDT_ICM_MSB    2
`define ICDT_ICM_LSB    0
`define ICDT_CASC_BIT   8
`define ICDT_TRIG_BIT   7
`define ICDT_TSTAT_BIT  6
`define ICDT_SSEL_MSB   4
`define ICDT_SSEL_LSB   0
`define ICDT_SSEL_RST   5'h0D
`define ICDT_SSEL_NONE  5'h00
`define ICDT_TSEL_T3    3'h0
`define ICDT_TSEL_T2    3'h1
`define ICDT_TSEL_T4    3'h2
`define ICDT_TSEL_T5    3'h3
`define ICDT_TSEL_T1    3'h4
`define ICDT_TSEL_SYS   3'h7
`define ICDT_CNT_MAX    16'hFFFF
`define ICDT_PRE4_LAST  4'h3
`define ICDT_PRE16_LAST 4'hF
`define ICDT_FIFO_FULL  3'h4
`endif

// ### shared/icdt_pkg.sv
// Types shared by the capture block
package icdt_pkg;
  typedef enum logic [2:0] {
    ICDT_M_OFF   = 3'b000,
    ICDT_M_EDGE  = 3'b001,
    ICDT_M_FALL  = 3'b010,
    ICDT_M_RISE  = 3'b011,
    ICDT_M_PRE4  = 3'b100,
    ICDT_M_PRE16 = 3'b101,
    ICDT_M_DIS   = 3'b110,
    ICDT_M_WAKE  = 3'b111
  } icdt_mode_t;
  typedef logic [15:0] icdt_word_t;
endpackage

// ### logic/icdt_capture.sv
// Five input capture units with dedicated counters behind an AHB-Lite slave
`timescale 1ns/100ps
`include "icdt_cfg.svh"
module icdt_capture (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [4:0]  captureInput,
  input  wire logic [4:0]  timerTick,
  input  wire logic [31:0] syncEvent,
  input  wire logic [31:0] syncSourceOn,
  input  wire logic        lowPowerIdle,
  output logic      [4:0]  captureIrq
);
  import icdt_pkg::*;

  localparam int N = `ICDT_UNITS;

  logic [31:0] con1Rd [N];
  logic [31:0] con2Rd [N];
  icdt_word_t  bufHead [N];
  logic [N-1:0] pop;
  logic [N-1:0] con1Wr;
  logic [N-1:0] con2Wr;
  logic [N-1:0] capEv;
  logic [N-1:0] wrapEv;
  logic [N-1:0] clrEv;
  logic [N-1:0] holdEv;
  logic [N-1:0] cascBit;
  logic [N-1:0] irqEv;
  logic [2:0]  modeOf [N];
  logic [1:0]  rateOf [N];
  logic [4:0]  pinMeta_q;
  logic [4:0]  pinSync_q;
  logic [4:0]  pinLast_q;

  // Bus address phase decode, unmapped space reads zero
  logic        addrOk;
  logic [2:0]  aUnit;
  logic [1:0]  aReg;
  logic        aMapped;
  logic        wrPend_q;
  logic [2:0]  wUnit_q;
  logic [1:0]  wReg_q;
  logic [31:0] rdMux;

  assign addrOk  = hsel && hready && htrans[1];
  assign aUnit   = haddr[`ICDT_UNIT_MSB:`ICDT_UNIT_LSB];
  assign aReg    = haddr[`ICDT_REG_MSB:`ICDT_REG_LSB];
  assign aMapped = (haddr[31:7] == 25'h0) && (aUnit < 3'(N)) && (aReg != 2'h3);

  always_comb begin
    rdMux = 32'h0;
    if (aMapped) begin
      unique case (aReg)
        `ICDT_OFF_CON1: rdMux = con1Rd[aUnit];
        `ICDT_OFF_CON2: rdMux = con2Rd[aUnit];
        `ICDT_OFF_BUF:  rdMux = {16'h0, bufHead[aUnit]};
        default:        rdMux = 32'h0;
      endcase
    end
  end

  // Address phase kept for the write data phase that follows
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wUnit_q  <= 3'h0;
      wReg_q   <= 2'h0;
    end else begin
      wrPend_q <= addrOk && hwrite && aMapped;
      wUnit_q  <= aUnit;
      wReg_q   <= aReg;
    end
  end

  // Registered response, never a wait state, always OKAY
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrOk && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  // Capture pins pass two flops, a third keeps the previous level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta_q <= 5'h0;
      pinSync_q <= 5'h0;
      pinLast_q <= 5'h0;
    end else begin
      pinMeta_q <= captureInput;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end

  // Per-unit configuration, counter, FIFO and interrupt state
  for (genvar u = 0; u < N; u++) begin : g_unit
    localparam bit IS_HI = (u % 2) == 1;
    localparam int LO = IS_HI ? u - 1 : u;
    logic [2:0]  tsel_q;
    logic [1:0]  ici_q;
    logic [2:0]  icm_q;
    logic        ov_q;
    logic        casc_q;
    logic        trig_q;
    logic        tstat_q;
    logic [4:0]  ssel_q;
    icdt_word_t  cnt_q;
    logic [3:0]  pre_q;
    logic [1:0]  icnt_q;
    logic        irq_q;
    icdt_word_t  fifo [4];
    logic [1:0]  wp_q;
    logic [1:0]  rp_q;
    logic [2:0]  fill_q;
    logic        tick;
    logic        syncHit;
    logic        pairOn;
    logic        incr;
    logic        rise;
    logic        fall;
    logic        ownCap;
    logic        cap;
    logic        push;
    icdt_mode_t  mode;

    assign mode = icdt_mode_t'(icm_q);
    // Last unit has no partner, so its pair flag is tied low
    if (u < N - 1 || IS_HI) begin : g_pair
      assign pairOn = cascBit[LO] && cascBit[LO + 1];
    end else begin : g_solo
      assign pairOn = 1'b0;
    end
    // Edge detect on the synchronised pin
    assign rise = pinSync_q[u] && !pinLast_q[u];
    assign fall = !pinSync_q[u] && pinLast_q[u];
    // Pulse from the selected sync or trigger source
    assign syncHit = (ssel_q != `ICDT_SSEL_NONE) && syncEvent[ssel_q];

    // Time-base selection
    always_comb begin
      unique case (tsel_q)
        `ICDT_TSEL_T3:  tick = timerTick[2];
        `ICDT_TSEL_T2:  tick = timerTick[1];
        `ICDT_TSEL_T4:  tick = timerTick[3];
        `ICDT_TSEL_T5:  tick = timerTick[4];
        `ICDT_TSEL_T1:  tick = timerTick[0];
        `ICDT_TSEL_SYS: tick = 1'b1;
        default:        tick = 1'b0;
      endcase
    end

    // Hold: trigger not yet fired, or cascaded sync waiting for its source
    assign holdEv[u] = (trig_q && !tstat_q)
                     || (casc_q && !trig_q && ssel_q != `ICDT_SSEL_NONE
                         && !syncSourceOn[ssel_q]);
    assign clrEv[u] = !trig_q && syncHit;
    assign incr = (IS_HI && pairOn) ? wrapEv[LO] : tick;
    assign wrapEv[u] = incr && (cnt_q == `ICDT_CNT_MAX);

    // Counter: cleared, held or counting; a paired high unit follows its low unit
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_q <= 16'h0;
      end else if (IS_HI && pairOn) begin
        if (holdEv[LO] || clrEv[LO]) begin
          cnt_q <= 16'h0;
        end else if (incr) begin
          cnt_q <= cnt_q + 16'h1;
        end
      end else if (holdEv[u] || clrEv[u]) begin
        cnt_q <= 16'h0;
      end else if (incr) begin
        cnt_q <= cnt_q + 16'h1;
      end
    end

    // Edge qualification with prescale
    always_comb begin
      unique case (mode)
        ICDT_M_EDGE:  ownCap = rise || fall;
        ICDT_M_FALL:  ownCap = fall;
        ICDT_M_RISE:  ownCap = rise;
        ICDT_M_PRE4:  ownCap = rise && pre_q == `ICDT_PRE4_LAST;
        ICDT_M_PRE16: ownCap = rise && pre_q == `ICDT_PRE16_LAST;
        ICDT_M_OFF, ICDT_M_DIS, ICDT_M_WAKE: ownCap = 1'b0;
      endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        pre_q <= 4'h0;
      end else if (mode != ICDT_M_PRE4 && mode != ICDT_M_PRE16) begin
        pre_q <= 4'h0;
      end else if (rise) begin
        pre_q <= (mode == ICDT_M_PRE4 && pre_q == `ICDT_PRE4_LAST) ? 4'h0 : pre_q + 4'h1;
      end
    end

    // Captures while the counter is held are ignored
    assign capEv[u] = ownCap && !holdEv[u];
    assign cap = (IS_HI && pairOn) ? capEv[LO] : capEv[u];
    assign push = cap && (fill_q != `ICDT_FIFO_FULL);
    assign modeOf[u] = icm_q;
    assign rateOf[u] = ici_q;

    // Capture FIFO
    always_ff @(posedge clk_sys) begin
      if (push) begin
        fifo[wp_q] <= cnt_q;
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        wp_q   <= 2'h0;
        rp_q   <= 2'h0;
        fill_q <= 3'h0;
      end else begin
        wp_q   <= wp_q + 2'(push);
        rp_q   <= rp_q + 2'(pop[u]);
        fill_q <= fill_q + 3'(push) - 3'(pop[u]);
      end
    end

    // Head entry is read and popped in the read address phase
    assign bufHead[u] = fifo[rp_q];
    assign pop[u] = addrOk && !hwrite && aMapped && aUnit == 3'(u)
                  && aReg == `ICDT_OFF_BUF && fill_q != 3'h0;

    // Overflow: set wins over the clear made by turning the unit off
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        ov_q <= 1'b0;
      end else if (cap && fill_q == `ICDT_FIFO_FULL) begin
        ov_q <= 1'b1;
      end else if (con1Wr[u] && hwdata[`ICDT_ICM_MSB:`ICDT_ICM_LSB] == ICDT_M_OFF) begin
        ov_q <= 1'b0;
      end
    end

    // Interrupt rate
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        icnt_q <= 2'h0;
        irq_q  <= 1'b0;
      end else begin
        irq_q <= 1'b0;
        if (IS_HI && pairOn) begin
          icnt_q <= 2'h0;
        end else if (mode == ICDT_M_WAKE) begin
          irq_q <= rise && lowPowerIdle;
        end else if (capEv[u]) begin
          if (mode == ICDT_M_EDGE || icnt_q == ici_q) begin
            irq_q  <= 1'b1;
            icnt_q <= 2'h0;
          end else begin
            icnt_q <= icnt_q + 2'h1;
          end
        end
      end
    end
    assign irqEv[u] = irq_q;

    // Control registers, written in the data phase
    assign con1Wr[u] = wrPend_q && wUnit_q == 3'(u) && wReg_q == `ICDT_OFF_CON1;
    assign con2Wr[u] = wrPend_q && wUnit_q == 3'(u) && wReg_q == `ICDT_OFF_CON2;

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        tsel_q <= 3'h0;
        ici_q  <= 2'h0;
        icm_q  <= 3'h0;
      end else if (con1Wr[u]) begin
        tsel_q <= hwdata[`ICDT_TSEL_MSB:`ICDT_TSEL_LSB];
        ici_q  <= hwdata[`ICDT_ICI_MSB:`ICDT_ICI_LSB];
        icm_q  <= hwdata[`ICDT_ICM_MSB:`ICDT_ICM_LSB];
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        casc_q <= 1'b0;
        trig_q <= 1'b0;
        ssel_q <= `ICDT_SSEL_RST;
      end else if (con2Wr[u]) begin
        casc_q <= hwdata[`ICDT_CASC_BIT];
        trig_q <= hwdata[`ICDT_TRIG_BIT];
        ssel_q <= hwdata[`ICDT_SSEL_MSB:`ICDT_SSEL_LSB];
      end
    end
    assign cascBit[u] = casc_q;

    // Trigger status: hardware set wins over a software clear
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        tstat_q <= 1'b0;
      end else if (trig_q && syncHit) begin
        tstat_q <= 1'b1;
      end else if (con2Wr[u]) begin
        tstat_q <= hwdata[`ICDT_TSTAT_BIT];
      end
    end

    // Read-back images of both control registers
    always_comb begin
      con1Rd[u] = 32'h0;
      con1Rd[u][`ICDT_TSEL_MSB:`ICDT_TSEL_LSB] = tsel_q;
      con1Rd[u][`ICDT_ICI_MSB:`ICDT_ICI_LSB]   = ici_q;
      con1Rd[u][`ICDT_OV_BIT]                  = ov_q;
      con1Rd[u][`ICDT_BNE_BIT]                 = fill_q != 3'h0;
      con1Rd[u][`ICDT_ICM_MSB:`ICDT_ICM_LSB]   = icm_q;
      con2Rd[u] = 32'h0;
      con2Rd[u][`ICDT_CASC_BIT]                = casc_q;
      con2Rd[u][`ICDT_TRIG_BIT]                = trig_q;
      con2Rd[u][`ICDT_TSTAT_BIT]               = tstat_q;
      con2Rd[u][`ICDT_SSEL_MSB:`ICDT_SSEL_LSB] = ssel_q;
    end
  end

  // Interrupt outputs leave straight from flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      captureIrq <= 5'h0;
    end else begin
      captureIrq <= irqEv;
    end
  end

endmodule

// ### test/icdt_capture_asserts.sv
// Port-level assertions for the capture block
`timescale 1ns/100ps
module icdt_capture_asserts (
  input logic        clk_sys,
  input logic        rst,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic [4:0]  captureInput,
  input logic [4:0]  timerTick,
  input logic [31:0] syncEvent,
  input logic [31:0] syncSourceOn,
  input logic        lowPowerIdle,
  input logic [4:0]  captureIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] pinPrev_q;
  logic [3:0] quiet_q [5];
  logic [4:0] recent;
  logic       rdTaken;
  assign rdTaken = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) pinPrev_q <= 5'h00;
    else pinPrev_q <= captureInput;
  end
  // Cycles since each pin last changed, saturating
  for (genvar i = 0; i < 5; i++) begin : g_quiet
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) quiet_q[i] <= 4'hF;
      else if (captureInput[i] != pinPrev_q[i]) quiet_q[i] <= 4'h0;
      else if (quiet_q[i] != 4'hF) quiet_q[i] <= quiet_q[i] + 4'h1;
    end
    assign recent[i] = quiet_q[i] < 4'hB;
  end
  property p_ready_high; hreadyout == 1'b1; endproperty
  a_ready_high: assert property (p_ready_high) else $error("wait state inserted");
  property p_resp_okay; hresp == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
  property p_irq_cause; |captureIrq |-> (captureIrq & ~recent) == 5'h00; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without pin edge");
  property p_rdata_hold; !$past(rdTaken) |-> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_far_zero; rdTaken && haddr[31:7] != 25'h0 |=> hrdata == 32'h0; endproperty
  a_far_zero: assert property (p_far_zero) else $error("far read not zero");
  property p_unit_zero; rdTaken && haddr[6:4] > 3'h4 |=> hrdata == 32'h0; endproperty
  a_unit_zero: assert property (p_unit_zero) else $error("sixth unit answered");
  property p_con1_blank;
    rdTaken && haddr[3:2] == 2'h0 |=> hrdata[31:13] == 19'h0 && hrdata[9:7] == 3'h0;
  endproperty
  a_con1_blank: assert property (p_con1_blank) else $error("control bits leak");
  property p_off_quiet; $fell(rst) |-> (captureIrq == 5'h00) [*3]; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
  c_irq: cover property (captureIrq[0]);
  c_unit: cover property (rdTaken && haddr[6:4] > 3'h4);
  c_pair: cover property (rdTaken && haddr == 32'h18);
endmodule

// ### test/icdt_pulse_src.sv
// Signal source on a capture pin: toggles a set number of times
`timescale 1ns/100ps
module icdt_pulse_src (
  input  logic        clk_sys,
  input  logic        rst,
  input  logic        goReq,
  input  logic [7:0]  toggleCnt,
  input  logic [15:0] gapCycles,
  output logic        pinOut,
  output logic        busy
);
  logic [7:0]  left_q;
  logic [15:0] tmr_q;
  assign busy = left_q != 8'h00;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_q <= 8'h00;
      tmr_q <= 16'h0001;
      pinOut <= 1'b0;
    end else if (goReq) begin
      left_q <= toggleCnt;
      tmr_q <= 16'h0001;
    end else if (busy) begin
      if (tmr_q == 16'h0001) begin
        pinOut <= ~pinOut;
        left_q <= left_q - 8'h01;
        tmr_q <= gapCycles;
      end else tmr_q <= tmr_q - 16'h0001;
    end
  end
endmodule

// ### test/testbench.sv
// Self-checking bench for the capture block
`timescale 1ns/100ps
module testbench;
  import icdt_pkg::*;
  logic        rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, lowPowerIdle = 1'b0;
  logic        clk_sys, hready, hreadyout, hresp, pin, busy;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  timerTick = 5'h00, captureInput, captureIrq;
  logic [7:0]  tgl = 8'h00;
  logic [15:0] gapC = 16'h0001;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, syncEvent = 32'h0, syncSourceOn = 32'hFFFFFFFF;
  logic [31:0] hrdata, rv, w32, p32, v0, v1;
  logic [31:0] bad [3] = '{32'h80, 32'h50, 32'hC};
  icdt_mode_t  idle [3] = '{ICDT_M_OFF, ICDT_M_DIS, ICDT_M_WAKE};
  int          dv [5] = '{15, 20, 12, 10, 30};
  int          errTotal = 0, numChecks = 0, irqN = 0, cyc = 0;
  assign hready = hreadyout;
  assign captureInput = {4'h0, pin};
  icdt_capture uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .captureInput(captureInput),
    .timerTick(timerTick), .syncEvent(syncEvent), .syncSourceOn(syncSourceOn),
    .lowPowerIdle(lowPowerIdle), .captureIrq(captureIrq));
  icdt_pulse_src src (.clk_sys(clk_sys), .rst(rst), .goReq(go), .toggleCnt(tgl),
    .gapCycles(gapC), .pinOut(pin), .busy(busy));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Timer k ticks every k+2 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (captureIrq[0] === 1'b1) irqN <= irqN + 1;
    for (int k = 0; k < 5; k++) timerTick[k] <= cyc % (k + 2) == 0;
  end
  task automatic giveVerdict();
    if (errTotal == 0 && numChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    numChecks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      errTotal++;
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 100);
    rv = hrdata;
    if (n > 40) begin
      errTotal++;
      giveVerdict();
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask
  task automatic sev();
    syncEvent <= 32'h2000;
    @(posedge clk_sys);
    syncEvent <= 32'h0;
    @(posedge clk_sys);
  endtask
  task automatic fire(input int n, g);
    int k;
    go <= 1'b1;
    tgl <= 8'(n);
    gapC <= 16'(g);
    @(posedge clk_sys);
    go <= 1'b0;
    k = 0;
    do @(posedge clk_sys); while (busy === 1'b1 && ++k < 90000);
    if (k >= 90000) begin
      errTotal++;
      giveVerdict();
    end
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic run(input logic [2:0] ts, input icdt_mode_t md, input logic [1:0] rt,
                     input int tg, cp, df);
    int i0, n;
    wr(32'h0, {19'h0, ts, 3'h0, rt, 5'h00});
    wr(32'h0, {19'h0, ts, 3'h0, rt, 2'h0, md});
    i0 = irqN;
    fire(tg, 30);
    xfer(1'b0, 32'h0, 32'h0);
    chk(32'(rv[4:3]), {cp > 4, cp > 0});
    n = 0;
    while (rv[3] === 1'b1 && n < 8) begin
      xfer(1'b0, 32'h8, 32'h0);
      if (n == 0) v0 = rv;
      if (n == 1) v1 = rv;
      n++;
      xfer(1'b0, 32'h0, 32'h0);
    end
    chk(n, cp > 4 ? 4 : cp);
    if (cp > 1) chk(32'(v1[15:0] - v0[15:0]), df);
    if (cp < 5) chk(irqN - i0, md == ICDT_M_EDGE ? cp : cp / (rt + 1));
    wr(32'h0, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rv, 32'h0);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rv, 32'hD);
    foreach (bad[i]) begin
      wr(bad[i], 32'hFFFFFFFF);
      xfer(1'b0, bad[i], 32'h0);
      chk(rv, 32'h0);
    end
    wr(32'h4, 32'h0);
    run(3'h7, ICDT_M_RISE, 2'h0, 4, 2, 60);
    for (int t = 0; t < 5; t++) run(3'(t), ICDT_M_RISE, 2'h0, 4, 2, dv[t]);
    run(3'h7, ICDT_M_FALL, 2'h1, 4, 2, 60);
    run(3'h7, ICDT_M_EDGE, 2'h3, 2, 2, 30);
    run(3'h7, ICDT_M_PRE4, 2'h0, 16, 2, 240);
    run(3'h7, ICDT_M_PRE16, 2'h0, 64, 2, 960);
    run(3'h7, ICDT_M_RISE, 2'h3, 8, 4, 60);
    run(3'h7, ICDT_M_RISE, 2'h0, 10, 5, 60);
    foreach (idle[i]) run(3'h7, idle[i], 2'h0, 4, 0, 0);
    syncSourceOn[13] <= 1'b0;
    wr(32'h4, 32'hD);
    wr(32'h0, 32'h1C01);
    syncSourceOn[13] <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      sev();
      repeat (10 + 15 * i) @(posedge clk_sys);
      fire(1, 2);
      xfer(1'b0, 32'h8, 32'h0);
      w32[16 * i +: 16] = rv[15:0];
    end
    chk(32'(w32[31:16] - w32[15:0]), 32'hF);
    for (int i = 0; i < 2; i++) begin
      wr(32'h4, i ? 32'h80 : 32'h8D);
      fire(1, 2);
      xfer(1'b0, 32'h0, 32'h0);
      chk(32'(rv[3]), 32'h0);
      if (i) wr(32'h4, 32'hC0);
      else sev();
      xfer(1'b0, 32'h4, 32'h0);
      chk(rv, i ? 32'hC0 : 32'hCD);
      fire(1, 2);
      xfer(1'b0, 32'h0, 32'h0);
      chk(32'(rv[3]), 32'h1);
      xfer(1'b0, 32'h8, 32'h0);
    end
    wr(32'h14, 32'h100);
    wr(32'h4, 32'h100);
    wr(32'h10, 32'h1C00);
    wr(32'h0, 32'h1C01);
    fire(4, 21846);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 32'h8, 32'h0);
      w32[15:0] = rv[15:0];
      xfer(1'b0, 32'h18, 32'h0);
      w32[31:16] = rv[15:0];
      if (i > 0) chk(w32 - p32, 32'h5556);
      p32 = w32;
    end
    giveVerdict();
  end
endmodule
bind icdt_capture icdt_capture_asserts ckr (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .captureInput(captureInput), .timerTick(timerTick), .syncEvent(syncEvent),
  .syncSourceOn(syncSourceOn), .lowPowerIdle(lowPowerIdle), .captureIrq(captureIrq));
